//--- core/pulse_counter_defines.svh
`ifndef PULSE_COUNTER_DEFINES_SVH
`define PULSE_COUNTER_DEFINES_SVH

// Counter count and register geometry
`define NUM_CTR 2
`define CTR_STRIDE 8'h20
// Per-counter register offsets, relative to counter base
`define CTRL_OFS 8'h00
`define UPPER_OFS 8'h04
`define LOWER_OFS 8'h08
`define ACC_OFS 8'h0c
`define PROBE_OFS 8'h10
`define RATE_OFS 8'h14
`define INTERVAL_OFS 8'h18
`define WINDOW_OFS 8'h1c
// Shared registers
`define STATUS_ADDR 8'h40
`define MASK_ADDR 8'h44
// Status and mask layout: overflow 2i, underflow 2i+1, probe event at 4
`define PROBE_BIT 4
`define STATUS_W 5
// Reset values
`define CTRL_RST 5'h00
`define UPPER_RST 32'hffff_ffff
`define LOWER_RST 32'h0000_0000
`define WINDOW_RST 32'h0000_2710
// Timing: interval timer resolution and clock period
`define TIMER_RES_NS 1000
`define CLK_PERIOD_NS 10
`define TICK_CYCLES (`TIMER_RES_NS / `CLK_PERIOD_NS)
`define TICK_W 7

`endif

//--- core/pulse_counter_pkg.sv
package pulse_counter_pkg;

    typedef logic [31:0] word_t;

    // Control word of one counter, bit 0 is the enable
    typedef struct packed {
        logic z_reset_en;
        logic z_hold_en;
        logic ext_rh_mode;
        logic wrap_or_saturate_select;
        logic counter_enable_bit;
    } ctrl_s;

endpackage : pulse_counter_pkg

//--- core/pulse_interval_timer.sv
`timescale 1ns/100ps
`include "pulse_counter_defines.svh"

module pulse_interval_timer
    import pulse_counter_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic us_tick,
    input wire logic pulse,
    output word_t pulse_interval_time
);

    word_t elapsed_q;
    word_t elapsed_d;
    word_t interval_q;
    word_t interval_d;
    logic seen_q;
    logic seen_d;

    // Elapsed time since the last pulse, published on the next one
    always_comb begin
        elapsed_d = elapsed_q;
        interval_d = interval_q;
        seen_d = seen_q;
        if (pulse) begin
            // First pulse only starts the measurement
            if (seen_q) begin
                interval_d = elapsed_q; // see RULE12 see RULE13
            end
            elapsed_d = '0;
            seen_d = 1'b1;
        end else if (us_tick && (elapsed_q != 32'hffff_ffff)) begin
            // Saturate so a stalled input reads as longest interval
            elapsed_d = elapsed_q + 32'h0000_0001; // see RULE13
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            elapsed_q <= '0;
            interval_q <= '0;
            seen_q <= 1'b0;
        end else begin
            elapsed_q <= elapsed_d;
            interval_q <= interval_d;
            seen_q <= seen_d;
        end
    end

    assign pulse_interval_time = interval_q;

endmodule : pulse_interval_timer

//--- core/pulse_counter_gate_limits.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "pulse_counter_defines.svh"

// Summary of operation
// RULE1 - A rising edge on the Z gate copies the current count into the probe register.
// RULE2 - With hold configured, Z high freezes the count and count pulses are dropped.
// RULE3 - With reset configured, each Z rising edge clears the current count.
// RULE4 - Several Z edges between host reads keep only the last capture, with no marker.
// RULE5 - The wrap-or-saturate bit picks ring counting at 0 and linear counting at 1.
// RULE6 - Ring mode: up count at the upper limit loads the lower limit and sets overflow.
// RULE7 - Ring mode: down count at the lower limit loads the upper limit and sets underflow.
// RULE8 - Linear mode: up count at the upper limit sets overflow and the count stays.
// RULE9 - Linear mode: down count at the lower limit sets underflow and the count stays.
// RULE10 - A cleared enable stops counting only; accumulator writes and Z functions still act.
// RULE11 - Rates are computed for every counter always, enabled or not, in any mode.
// RULE12 - Counters 0 and 1 measure the time between two successive input pulses.
// RULE13 - The interval timer ticks every 1 us and publishes after every pulse; the code publishes from the second pulse on.
// RULE14 - A cyclic rate counts pulses over a host-set window and is read beside the count.
// RULE15 - Z hold and reset act only when the external reset and hold mode is selected.
// RULE16 - A limit event in the same cycle as its clear leaves the flag set.
// RULE17 - A Z reset coinciding with a count pulse wins and the count becomes zero.

module pulse_counter_gate_limits
    import pulse_counter_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic z_gate_input,
    input wire logic [`NUM_CTR-1:0] up_pulse,
    input wire logic [`NUM_CTR-1:0] down_pulse,
    input wire logic [7:0] reg_addr,
    input wire word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output word_t reg_rdata,
    output logic irq
);

    // Address match, shared by the per-counter write decodes and the read mux
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] base,
                                     input logic [7:0] ofs);
        reg_hit = (a == (base + ofs));
    endfunction : reg_hit

    // Per-counter state, one element per counter
    ctrl_s ctrl_q [`NUM_CTR];
    ctrl_s ctrl_d [`NUM_CTR];
    word_t upper_q [`NUM_CTR];
    word_t upper_d [`NUM_CTR];
    word_t lower_q [`NUM_CTR];
    word_t lower_d [`NUM_CTR];
    word_t count_q [`NUM_CTR];
    word_t count_d [`NUM_CTR];
    word_t probe_q [`NUM_CTR];
    word_t probe_d [`NUM_CTR];
    word_t window_q [`NUM_CTR];
    word_t window_d [`NUM_CTR];
    word_t win_cnt_q [`NUM_CTR];
    word_t win_cnt_d [`NUM_CTR];
    word_t pulses_q [`NUM_CTR];
    word_t pulses_d [`NUM_CTR];
    word_t rate_q [`NUM_CTR];
    word_t rate_d [`NUM_CTR];
    word_t interval [`NUM_CTR];
    logic ovf_q [`NUM_CTR];
    logic ovf_d [`NUM_CTR];
    logic unf_q [`NUM_CTR];
    logic unf_d [`NUM_CTR];

    // Shared state
    logic z_meta_q;
    logic z_sync_q;
    logic z_prev_q;
    logic z_rise;
    logic probe_evt_q;
    logic probe_evt_d;
    logic [`STATUS_W-1:0] mask_q;
    logic [`STATUS_W-1:0] mask_d;
    logic [`STATUS_W-1:0] status;
    logic [`STATUS_W-1:0] status_clr;
    logic [`TICK_W-1:0] tick_cnt_q;
    logic [`TICK_W-1:0] tick_cnt_d;
    logic us_tick;
    word_t rdata_q;
    word_t rdata_d;

    // Z is a pin: two flops before any logic looks at it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            z_meta_q <= 1'b0;
            z_sync_q <= 1'b0;
            z_prev_q <= 1'b0;
        end else begin
            z_meta_q <= z_gate_input;
            z_sync_q <= z_meta_q;
            z_prev_q <= z_sync_q;
        end
    end

    assign z_rise = z_sync_q & ~z_prev_q;

    // Microsecond tick shared by the interval timers and rate windows
    always_comb begin
        if (tick_cnt_q == `TICK_W'(`TICK_CYCLES - 1)) begin
            tick_cnt_d = '0;
        end else begin
            tick_cnt_d = tick_cnt_q + `TICK_W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    assign us_tick = (tick_cnt_q == `TICK_W'(`TICK_CYCLES - 1)); // see RULE13

    // W1C decode of the shared status word
    assign status_clr = (reg_wr && (reg_addr == `STATUS_ADDR)) ?
                        reg_wdata[`STATUS_W-1:0] : '0;

    genvar i;
    generate
        for (i = 0; i < `NUM_CTR; i++) begin : g_ctr
            localparam logic [7:0] BASE = 8'(i) * `CTR_STRIDE;
            // Only counter 0 owns the Z gate
            localparam logic HAS_Z = (i == 0);

            logic up;
            logic dn;
            logic any_pulse;
            logic z_edge;
            logic z_gated;
            logic hold;
            logic zreset;
            logic ovf_set;
            logic unf_set;

            // Opposite pulses in one cycle cancel; the rate and interval timer see them as one pulse
            assign up = up_pulse[i] & ~down_pulse[i];
            assign dn = down_pulse[i] & ~up_pulse[i];
            assign any_pulse = up_pulse[i] | down_pulse[i];
            assign z_edge = HAS_Z & z_rise;
            // Hold and reset only in modes with external reset and hold
            assign z_gated = HAS_Z & ctrl_q[i].ext_rh_mode; // see RULE15
            assign hold = z_gated & ctrl_q[i].z_hold_en & z_sync_q; // see RULE2
            assign zreset = z_gated & ctrl_q[i].z_reset_en & z_rise; // see RULE3

            // Counting, limits and host writes of one counter
            always_comb begin
                ctrl_d[i] = ctrl_q[i];
                upper_d[i] = upper_q[i];
                lower_d[i] = lower_q[i];
                window_d[i] = window_q[i];
                count_d[i] = count_q[i];
                probe_d[i] = probe_q[i];
                ovf_set = 1'b0;
                unf_set = 1'b0;
                if (reg_wr && reg_hit(reg_addr, BASE, `CTRL_OFS)) begin
                    ctrl_d[i] = ctrl_s'(reg_wdata[$bits(ctrl_s)-1:0]);
                end
                if (reg_wr && reg_hit(reg_addr, BASE, `UPPER_OFS)) begin
                    upper_d[i] = reg_wdata;
                end
                if (reg_wr && reg_hit(reg_addr, BASE, `LOWER_OFS)) begin
                    lower_d[i] = reg_wdata;
                end
                if (reg_wr && reg_hit(reg_addr, BASE, `WINDOW_OFS)) begin
                    window_d[i] = reg_wdata;
                end
                // Capture sees the count before this cycle's update
                if (z_edge) begin
                    probe_d[i] = count_q[i]; // see RULE1 see RULE4
                end
                // Priority: host write, then Z reset, then counting
                if (reg_wr && reg_hit(reg_addr, BASE, `ACC_OFS)) begin
                    count_d[i] = reg_wdata; // see RULE10
                end else if (zreset) begin
                    count_d[i] = '0; // see RULE17 see RULE10
                end else if (ctrl_q[i].counter_enable_bit && !hold) begin
                    if (up) begin
                        if (count_q[i] == upper_q[i]) begin
                            ovf_set = 1'b1;
                            // Ring reloads, linear stays at the limit
                            if (!ctrl_q[i].wrap_or_saturate_select) begin // see RULE5
                                count_d[i] = lower_q[i]; // see RULE6
                            end // see RULE8
                        end else begin
                            count_d[i] = count_q[i] + 32'h0000_0001;
                        end
                    end else if (dn) begin
                        if (count_q[i] == lower_q[i]) begin
                            unf_set = 1'b1;
                            if (!ctrl_q[i].wrap_or_saturate_select) begin // see RULE5
                                count_d[i] = upper_q[i]; // see RULE7
                            end // see RULE9
                        end else begin
                            count_d[i] = count_q[i] - 32'h0000_0001;
                        end
                    end
                end
                // Set wins over a clear in the same cycle
                ovf_d[i] = ovf_set | (ovf_q[i] & ~status_clr[2*i]); // see RULE16
                unf_d[i] = unf_set | (unf_q[i] & ~status_clr[2*i+1]); // see RULE16
            end

            // Cyclic rate, independent of enable and mode
            always_comb begin
                win_cnt_d[i] = win_cnt_q[i];
                pulses_d[i] = pulses_q[i];
                rate_d[i] = rate_q[i];
                if (us_tick && (win_cnt_q[i] + 32'h0000_0001 >= window_q[i])) begin
                    // Window closes; a pulse in this cycle opens the next
                    rate_d[i] = pulses_q[i]; // see RULE14 see RULE11
                    pulses_d[i] = any_pulse ? 32'h0000_0001 : '0;
                    win_cnt_d[i] = '0;
                end else begin
                    if (us_tick) begin
                        win_cnt_d[i] = win_cnt_q[i] + 32'h0000_0001;
                    end
                    if (any_pulse && (pulses_q[i] != 32'hffff_ffff)) begin
                        pulses_d[i] = pulses_q[i] + 32'h0000_0001; // see RULE11
                    end
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    ctrl_q[i] <= ctrl_s'(`CTRL_RST);
                    upper_q[i] <= `UPPER_RST;
                    lower_q[i] <= `LOWER_RST;
                    window_q[i] <= `WINDOW_RST;
                    count_q[i] <= '0;
                    probe_q[i] <= '0;
                    ovf_q[i] <= 1'b0;
                    unf_q[i] <= 1'b0;
                    win_cnt_q[i] <= '0;
                    pulses_q[i] <= '0;
                    rate_q[i] <= '0;
                end else begin
                    ctrl_q[i] <= ctrl_d[i];
                    upper_q[i] <= upper_d[i];
                    lower_q[i] <= lower_d[i];
                    window_q[i] <= window_d[i];
                    count_q[i] <= count_d[i];
                    probe_q[i] <= probe_d[i];
                    ovf_q[i] <= ovf_d[i];
                    unf_q[i] <= unf_d[i];
                    win_cnt_q[i] <= win_cnt_d[i];
                    pulses_q[i] <= pulses_d[i];
                    rate_q[i] <= rate_d[i];
                end
            end

            // Interval between successive pulses on counters 0 and 1
            pulse_interval_timer u_interval (
                .clk(clk),
                .arst_n(arst_n),
                .us_tick(us_tick),
                .pulse(any_pulse), // see RULE12
                .pulse_interval_time(interval[i])
            );

            assign status[2*i] = ovf_q[i];
            assign status[2*i+1] = unf_q[i];
        end
    endgenerate

    // Probe event flag and interrupt mask
    always_comb begin
        probe_evt_d = z_rise | (probe_evt_q & ~status_clr[`PROBE_BIT]);
        mask_d = mask_q;
        if (reg_wr && (reg_addr == `MASK_ADDR)) begin
            mask_d = reg_wdata[`STATUS_W-1:0];
        end
    end

    assign status[`PROBE_BIT] = probe_evt_q;

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rdata_d = '0;
        if (reg_addr == `STATUS_ADDR) begin
            rdata_d = {{(32-`STATUS_W){1'b0}}, status};
        end else if (reg_addr == `MASK_ADDR) begin
            rdata_d = {{(32-`STATUS_W){1'b0}}, mask_q};
        end
        for (int c = 0; c < `NUM_CTR; c++) begin
            if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `CTRL_OFS)) begin
                rdata_d = {{(32-$bits(ctrl_s)){1'b0}}, ctrl_q[c]};
            end else if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `UPPER_OFS)) begin
                rdata_d = upper_q[c];
            end else if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `LOWER_OFS)) begin
                rdata_d = lower_q[c];
            end else if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `ACC_OFS)) begin
                rdata_d = count_q[c];
            end else if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `PROBE_OFS)) begin
                rdata_d = probe_q[c];
            end else if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `RATE_OFS)) begin
                rdata_d = rate_q[c];
            end else if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `INTERVAL_OFS)) begin
                rdata_d = interval[c];
            end else if (reg_hit(reg_addr, 8'(c) * `CTR_STRIDE, `WINDOW_OFS)) begin
                rdata_d = window_q[c];
            end
        end
        // Data only stands in the cycle after a read strobe
        if (!reg_rd) begin
            rdata_d = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            probe_evt_q <= 1'b0;
            mask_q <= '0;
            rdata_q <= '0;
        end else begin
            probe_evt_q <= probe_evt_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    // Level interrupt while any unmasked status bit is set
    assign irq = |(status & mask_q);

endmodule : pulse_counter_gate_limits

//--- tb/pulse_counter_gate_limits_sva.sv
`timescale 1ns/100ps
`include "pulse_counter_defines.svh"

module pulse_counter_gate_limits_sva
    import pulse_counter_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic z_gate_input,
    input wire logic [`NUM_CTR-1:0] up_pulse,
    input wire logic [`NUM_CTR-1:0] down_pulse,
    input wire logic [7:0] reg_addr,
    input wire word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire word_t reg_rdata,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // No count traffic, so register readback is not disturbed
    logic quiet;
    assign quiet = (up_pulse == '0) && (down_pulse == '0);

    // Read bus and register readback
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data present without a read strobe");
    chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'hf0 |=> reg_rdata == 32'h0)
        else $error("unmapped read returned nonzero");
    chk_acc_load: assert property (
        reg_wr && reg_addr == `ACC_OFS && quiet ##1 reg_rd && reg_addr == `ACC_OFS && quiet
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("accumulator write not loaded");
    chk_status_clear: assert property (
        reg_wr && reg_addr == `STATUS_ADDR && reg_wdata[4:0] == 5'h1f && quiet
        ##1 reg_rd && reg_addr == `STATUS_ADDR && quiet |=> reg_rdata == 32'h0)
        else $error("status bits not cleared by write of ones");
    chk_ctrl_back: assert property (
        reg_wr && reg_addr == `CTRL_OFS ##1 reg_rd && reg_addr == `CTRL_OFS
        |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 2))
        else $error("control readback differs");
    chk_upper_back: assert property (
        reg_wr && reg_addr == `UPPER_OFS ##1 reg_rd && reg_addr == `UPPER_OFS
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("upper limit readback differs");

    // Interrupt level follows status and mask
    chk_mask_off: assert property (reg_wr && reg_addr == `MASK_ADDR && reg_wdata == 32'h0 |=> !irq)
        else $error("interrupt high with all sources masked");
    chk_irq_fall: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("interrupt dropped without a host write");
    // Z edges reach status only after the synchroniser, hence the deep look back
    chk_irq_rise: assert property ($rose(irq) |-> $past(reg_wr) || $past(!quiet)
        || $past(z_gate_input, 3) || $past(z_gate_input, 4) || $past(z_gate_input, 5))
        else $error("interrupt rose without a cause");
endmodule : pulse_counter_gate_limits_sva

//--- tb/pulse_source.sv
`timescale 1ns/100ps
`include "pulse_counter_defines.svh"

module pulse_source (
    input wire logic clk,
    output logic z_gate_input,
    output logic [`NUM_CTR-1:0] up_pulse,
    output logic [`NUM_CTR-1:0] down_pulse
);
    // Lines idle low like a quiet encoder
    initial begin
        z_gate_input = 1'b0;
        up_pulse = '0;
        down_pulse = '0;
    end

    // One-cycle pulses with a gap, so each is a separate count
    task automatic send(input logic [`NUM_CTR-1:0] up, input logic [`NUM_CTR-1:0] dn);
        up_pulse <= up;
        down_pulse <= dn;
        @(posedge clk);
        up_pulse <= '0;
        down_pulse <= '0;
        @(posedge clk);
    endtask : send

    task automatic set_z(input logic lvl);
        z_gate_input <= lvl;
        @(posedge clk);
    endtask : set_z

    // Long enough to pass the two-flop synchroniser
    task automatic z_pulse;
        set_z(1'b1);
        repeat (4) @(posedge clk);
        set_z(1'b0);
        repeat (4) @(posedge clk);
    endtask : z_pulse
endmodule : pulse_source

//--- tb/test_pulse_counter_gate_limits.sv
`timescale 1ns/100ps
`include "pulse_counter_defines.svh"

module test_pulse_counter_gate_limits
    import pulse_counter_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    word_t reg_wdata = 32'h0;
    word_t reg_rdata;
    logic irq;
    logic z_gate_input;
    logic [`NUM_CTR-1:0] up_pulse;
    logic [`NUM_CTR-1:0] down_pulse;
    int n_mismatch = 0;
    int check_count = 0;

    always #5 clk = ~clk;

    pulse_counter_gate_limits pulse_counter_gate_limits_i (.clk(clk), .arst_n(arst_n),
        .z_gate_input(z_gate_input), .up_pulse(up_pulse), .down_pulse(down_pulse),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    pulse_source pulse_source_i (.clk(clk), .z_gate_input(z_gate_input),
        .up_pulse(up_pulse), .down_pulse(down_pulse));

    task automatic check32(input word_t got, input word_t exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    // Measured values carry tick phase jitter, so a window is accepted
    task automatic check_range(input word_t got, input word_t lo, input word_t hi);
        check_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : check_range

    // Bus tasks enter just after an edge and leave just after an edge
    task automatic wr(input logic [7:0] a, input word_t d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output word_t d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask : rd

    task automatic rd_check(input logic [7:0] a, input word_t exp);
        word_t got;
        rd(a, got);
        check32(got, exp);
    endtask : rd_check

    // Write followed by a read with no gap
    task automatic wr_rd(input logic [7:0] a, input word_t d, input logic [7:0] ra,
                         input word_t exp);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        rd_check(ra, exp);
    endtask : wr_rd

    task automatic t_reset_values;
        logic [7:0] a [7] = '{`CTRL_OFS, `UPPER_OFS, `LOWER_OFS, `WINDOW_OFS, `STATUS_ADDR,
                              `MASK_ADDR, 8'hf0};
        word_t e [7] = '{32'h0, `UPPER_RST, `LOWER_RST, `WINDOW_RST, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rd_check(a[i], e[i]);
        end
        wr_rd(`PROBE_OFS, 32'h0000_00aa, `PROBE_OFS, 32'h0);
    endtask : t_reset_values

    task automatic t_ring;
        wr(`MASK_ADDR, 32'h3);
        wr_rd(`UPPER_OFS, 32'h5, `UPPER_OFS, 32'h5);
        wr(`LOWER_OFS, 32'h2);
        wr(`CTRL_OFS, 32'h1);
        wr_rd(`ACC_OFS, 32'h5, `ACC_OFS, 32'h5);
        pulse_source_i.send(2'b01, 2'b00);
        rd_check(`ACC_OFS, 32'h2);
        rd_check(`STATUS_ADDR, 32'h1);
        check_bit(irq, 1'b1);
        wr_rd(`STATUS_ADDR, 32'h1f, `STATUS_ADDR, 32'h0);
        check_bit(irq, 1'b0);
        pulse_source_i.send(2'b00, 2'b01);
        rd_check(`ACC_OFS, 32'h5);
        rd_check(`STATUS_ADDR, 32'h2);
        wr(`MASK_ADDR, 32'h0);
        check_bit(irq, 1'b0);
        // Limit event lands in the same cycle as the clear
        fork
            pulse_source_i.send(2'b01, 2'b00);
            wr(`STATUS_ADDR, 32'h1f);
        join
        rd_check(`STATUS_ADDR, 32'h1);
    endtask : t_ring

    task automatic t_linear;
        wr(`STATUS_ADDR, 32'h1f);
        wr_rd(`CTRL_OFS, 32'h3, `CTRL_OFS, 32'h3);
        wr(`ACC_OFS, 32'h5);
        pulse_source_i.send(2'b01, 2'b00);
        rd_check(`ACC_OFS, 32'h5);
        wr(`ACC_OFS, 32'h2);
        pulse_source_i.send(2'b00, 2'b01);
        rd_check(`ACC_OFS, 32'h2);
        rd_check(`STATUS_ADDR, 32'h3);
        wr(`STATUS_ADDR, 32'h1f);
        // Disabled: pulses ignored, direct load still works
        wr(`CTRL_OFS, 32'h0);
        wr_rd(`ACC_OFS, 32'h0000_1234, `ACC_OFS, 32'h0000_1234);
        pulse_source_i.send(2'b01, 2'b00);
        rd_check(`ACC_OFS, 32'h0000_1234);
    endtask : t_linear

    task automatic t_zgate;
        wr(`CTRL_OFS, 32'h15);
        wr(`ACC_OFS, 32'h7);
        pulse_source_i.z_pulse();
        rd_check(`PROBE_OFS, 32'h7);
        rd_check(`ACC_OFS, 32'h0);
        rd_check(`STATUS_ADDR, 32'h10);
        wr(`STATUS_ADDR, 32'h1f);
        // Count pulse on the very edge that applies the Z reset
        wr(`ACC_OFS, 32'h9);
        pulse_source_i.set_z(1'b1);
        // Sync flops take one more edge; the pulse then lands with the reset
        repeat (1) @(posedge clk);
        pulse_source_i.send(2'b01, 2'b00);
        pulse_source_i.set_z(1'b0);
        repeat (4) @(posedge clk);
        rd_check(`ACC_OFS, 32'h0);
        // Plain mode: Z only captures, never clears
        wr(`CTRL_OFS, 32'h11);
        wr(`ACC_OFS, 32'h9);
        pulse_source_i.z_pulse();
        rd_check(`ACC_OFS, 32'h9);
        wr(`ACC_OFS, 32'h3);
        pulse_source_i.z_pulse();
        rd_check(`PROBE_OFS, 32'h3);
        rd_check(`STATUS_ADDR, 32'h10);
        wr(`STATUS_ADDR, 32'h1f);
        // Hold while Z is high
        wr(`CTRL_OFS, 32'h0d);
        wr(`ACC_OFS, 32'h4);
        pulse_source_i.set_z(1'b1);
        repeat (3) @(posedge clk);
        pulse_source_i.send(2'b01, 2'b00);
        rd_check(`ACC_OFS, 32'h4);
        pulse_source_i.set_z(1'b0);
        repeat (4) @(posedge clk);
        pulse_source_i.send(2'b01, 2'b00);
        rd_check(`ACC_OFS, 32'h5);
        wr(`STATUS_ADDR, 32'h1f);
    endtask : t_zgate

    task automatic t_rates;
        word_t got;
        wr(`CTRL_OFS, 32'h0);
        wr(`WINDOW_OFS, 32'h5);
        // One pulse every 2 cycles, 250 per 5 us window
        for (int i = 0; i < 600; i++) begin
            pulse_source_i.send(2'b01, 2'b10);
        end
        rd(`RATE_OFS, got);
        check_range(got, 32'd249, 32'd251);
        repeat (1000) @(posedge clk);
        pulse_source_i.send(2'b00, 2'b10);
        rd(`CTR_STRIDE + `INTERVAL_OFS, got);
        check_range(got, 32'd9, 32'd11);
    endtask : t_rates

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_ring();
        t_linear();
        t_zgate();
        t_rates();
        summarize();
    end
endmodule : test_pulse_counter_gate_limits

bind pulse_counter_gate_limits pulse_counter_gate_limits_sva pulse_counter_gate_limits_sva_i (
    .clk(clk), .arst_n(arst_n), .z_gate_input(z_gate_input), .up_pulse(up_pulse),
    .down_pulse(down_pulse), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
